// file: uhet_pkg.sv
/*
  Constants, state encodings and carrier structs for the hub event timer.
  Assumes a single 250 MHz system clock; all intervals are counted on it.
*/
`default_nettype none
package uhet_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;

  // Interval figures in ns
  localparam int unsigned T_FILT_NS = 2500;
  localparam int unsigned T_DISC_NS = 2250;
  localparam int unsigned T_RSM_DN_NS = 20_000_000;
  localparam int unsigned T_RST_DN_NS = 15_000_000;
  localparam int unsigned T_CHIRP_NS = 50_000;
  localparam int unsigned T_DCHSE0_NS = 300_000;
  localparam int unsigned T_RSM_UP_NS = 5_000_000;
  localparam int unsigned T_WTREV_NS = 3_062_500;
  localparam int unsigned T_UCH_NS = 2_000_000;
  localparam int unsigned T_WTFS_NS = 1_500_000;
  localparam int unsigned T_WARM_NS = 150_000_000;

  // Cycle counts, rounded up to whole clocks
  localparam int unsigned CYC_FILT = (T_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_DISC = (T_DISC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_RSM_DN = (T_RSM_DN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_RST_DN = (T_RST_DN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_CHIRP = (T_CHIRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_DCHSE0 = (T_DCHSE0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_RSM_UP = (T_RSM_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_WTREV = (T_WTREV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_UCH = (T_UCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_WTFS = (T_WTFS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_WARM = (T_WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // High-speed bit times to clocks: bits * 1000 / (480 MHz * 4 ns), rounded up
  localparam int unsigned HS_BIT_MHZ = 480;
  localparam int unsigned GAP_SAME_BITS = 88;
  localparam int unsigned GAP_OPP_BITS = 8;
  localparam int unsigned GAP_DIV = HS_BIT_MHZ * CLK_PERIOD_NS;
  localparam int unsigned CYC_GAP_SAME = (GAP_SAME_BITS * 1000 + GAP_DIV - 1) / GAP_DIV;
  localparam int unsigned CYC_GAP_OPP = (GAP_OPP_BITS * 1000 + GAP_DIV - 1) / GAP_DIV;
  localparam logic [7:0] GAP_SAME_C = 8'(CYC_GAP_SAME);
  localparam logic [7:0] GAP_OPP_C = 8'(CYC_GAP_OPP);

  localparam logic [10:0] BABBLE_SYMS = 11'h406;
  localparam logic [10:0] SYM_RESET = 11'h000;
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;

  typedef enum logic [4:0] {
    DR_IDLE = 5'h01, DR_WAIT = 5'h02, DR_DEVK = 5'h04, DR_CHIRP = 5'h08, DR_TAIL = 5'h10
  } uhet_dr_state_type;

  typedef enum logic [4:0] {
    UP_FS = 5'h01, UP_HS = 5'h02, UP_REV = 5'h04, UP_CHIRP = 5'h08, UP_WAIT = 5'h10
  } uhet_up_state_type;

  // Line states from the transceivers, asynchronous to ref_clk
  typedef struct packed {
    logic dn_attach;
    logic dn_detach;
    logic dn_resume;
    logic dn_chirp_k;
    logic dn_rxdet;
    logic up_se0;
    logic up_k;
    logic up_chirp_kj;
  } uhet_pins_type;

  localparam int unsigned PIN_W = $bits(uhet_pins_type);

  // Requests from hub core logic on ref_clk; pulses except the levels warm_reset and up_u3
  typedef struct packed {
    logic port_reset;
    logic resume_dn;
    logic resume_up;
    logic warm_reset;
    logic up_u3;
    logic ss_route_lp;
    logic ss_remote_wake;
    logic dpp_start;
    logic dpp_sym;
    logic dpp_end;
    logic hs_tx_end;
    logic hs_rx_end;
  } uhet_req_type;

  typedef struct packed {
    logic connect;
    logic disconnect;
    logic resume_dn_drv;
    logic resume_bcast;
    logic reset_drv;
    logic chirp_k_dn;
    logic chirp_j_dn;
    logic long_k;
    logic long_se0;
    logic up_chirp_k;
    logic hs_mode;
    logic resume_up_drv;
    logic gap_ok;
    logic u0_exit;
    logic babble;
    logic wake_up;
    logic warm_fail;
  } uhet_out_type;

endpackage : uhet_pkg
`default_nettype wire

// file: uhet_persist.sv
/*
  Persistence filter: raises hit once its level input has been high for
  LIMIT consecutive clocks. Assumes level is already synchronised.
*/
`timescale 1ns/10ps
`default_nettype none
module uhet_persist
  import uhet_pkg::*;
#(
  parameter int unsigned LIMIT = CYC_FILT
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic level,
  output logic hit
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic hit_reg;
  logic hit_next;

  always_comb begin
    cnt_next = CNT_ZERO;
    if (level) begin
      cnt_next = (cnt_reg == LIMIT) ? cnt_reg : cnt_reg + 32'h0000_0001;
    end
    hit_next = level && (cnt_next == LIMIT);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= CNT_ZERO;
      hit_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      hit_reg <= hit_next;
    end
  end

  assign hit = hit_reg;

  a_hit_persist: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(hit_reg) |-> cnt_reg == LIMIT && $past(level))
    else $error("filter fired before the level persisted");

endmodule : uhet_persist
`default_nettype wire

// file: uhet_top.sv
/*
  Hub port event timer: line-state filters, downstream reset and chirp
  sequencing, upstream high-speed handshake, resume timing, packet gaps
  and SuperSpeed hub limits.
  Assumes pins are asynchronous line states, requests come from hub core
  logic on ref_clk (250 MHz), and the core acts on the event outputs.
*/
`timescale 1ns/10ps
`default_nettype none
module uhet_top
  import uhet_pkg::*;
#(
  parameter int unsigned RSM_DN_CYC = CYC_RSM_DN,
  parameter int unsigned RST_DN_CYC = CYC_RST_DN,
  parameter int unsigned CHIRP_CYC = CYC_CHIRP,
  parameter int unsigned DCHSE0_CYC = CYC_DCHSE0,
  parameter int unsigned RSM_UP_CYC = CYC_RSM_UP,
  parameter int unsigned REV_CYC = CYC_WTREV,
  parameter int unsigned UCH_CYC = CYC_UCH,
  parameter int unsigned WTFS_CYC = CYC_WTFS,
  parameter int unsigned WARM_CYC = CYC_WARM
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire uhet_pins_type pins,
  input wire uhet_req_type req,
  output var uhet_out_type evt
);

  localparam int unsigned TAIL_CYC = DCHSE0_CYC + CHIRP_CYC;

  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  uhet_pins_type pins_s;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign pins_s = uhet_pins_type'(sync2_reg);

  logic attach_hit;
  logic detach_hit;
  logic devk_hit;
  logic longk_hit;
  logic se0_hit;
  logic host_hit;
  logic warm_hit;
  logic warm_level;

  assign warm_level = pins_s.dn_rxdet && req.warm_reset;

  // Connect filter: 2.5 us meets both the awake and suspended ceilings
  uhet_persist #(.LIMIT(CYC_FILT)) u_attach (.ref_clk(ref_clk), .arst_n(arst_n),
    .level(pins_s.dn_attach), .hit(attach_hit));
  uhet_persist #(.LIMIT(CYC_DISC)) u_detach (.ref_clk(ref_clk), .arst_n(arst_n),
    .level(pins_s.dn_detach), .hit(detach_hit));
  uhet_persist #(.LIMIT(CYC_FILT)) u_devk (.ref_clk(ref_clk), .arst_n(arst_n),
    .level(pins_s.dn_chirp_k), .hit(devk_hit));
  uhet_persist #(.LIMIT(CYC_FILT)) u_longk (.ref_clk(ref_clk), .arst_n(arst_n),
    .level(pins_s.up_k), .hit(longk_hit));
  uhet_persist #(.LIMIT(CYC_FILT)) u_se0 (.ref_clk(ref_clk), .arst_n(arst_n),
    .level(pins_s.up_se0), .hit(se0_hit));
  uhet_persist #(.LIMIT(CYC_FILT)) u_host (.ref_clk(ref_clk), .arst_n(arst_n),
    .level(pins_s.up_chirp_kj), .hit(host_hit));
  uhet_persist #(.LIMIT(WARM_CYC)) u_warm (.ref_clk(ref_clk), .arst_n(arst_n),
    .level(warm_level), .hit(warm_hit));

  // Downstream reset and chirp sequence
  uhet_dr_state_type dr_reg;
  uhet_dr_state_type dr_next;
  logic [31:0] rst_cnt_reg;
  logic [31:0] rst_cnt_next;
  logic [31:0] chp_cnt_reg;
  logic [31:0] chp_cnt_next;
  logic chp_k_reg;
  logic chp_k_next;

  always_comb begin
    dr_next = dr_reg;
    rst_cnt_next = (rst_cnt_reg == CNT_ZERO) ? CNT_ZERO : rst_cnt_reg - 32'h0000_0001;
    chp_cnt_next = chp_cnt_reg;
    chp_k_next = chp_k_reg;
    case (dr_reg)
      DR_IDLE: begin
        rst_cnt_next = CNT_ZERO;
        if (req.port_reset) begin
          dr_next = DR_WAIT;
          rst_cnt_next = RST_DN_CYC - 1;
        end
      end
      DR_WAIT: begin
        if (devk_hit) begin
          dr_next = DR_DEVK;
        end
      end
      DR_DEVK: begin
        if (!devk_hit) begin
          // Chirp starts the cycle after the device K ends
          dr_next = (rst_cnt_reg < TAIL_CYC) ? DR_TAIL : DR_CHIRP;
          chp_cnt_next = CNT_ZERO;
          chp_k_next = 1'b1;
        end
      end
      DR_CHIRP: begin
        chp_cnt_next = chp_cnt_reg + 32'h0000_0001;
        if (chp_cnt_reg == CHIRP_CYC - 1) begin
          chp_cnt_next = CNT_ZERO;
          chp_k_next = !chp_k_reg;
          if (rst_cnt_reg < TAIL_CYC) begin
            // Whole chirps only, so the last ends before the final DCHSE0_CYC tail window
            dr_next = DR_TAIL;
          end
        end
      end
      DR_TAIL: begin
        dr_next = DR_TAIL;
      end
      default: begin
        dr_next = DR_IDLE;
      end
    endcase
    if (dr_reg != DR_IDLE && rst_cnt_reg == CNT_ZERO) begin
      dr_next = DR_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dr_reg <= DR_IDLE;
      rst_cnt_reg <= CNT_ZERO;
      chp_cnt_reg <= CNT_ZERO;
      chp_k_reg <= 1'b0;
    end else begin
      dr_reg <= dr_next;
      rst_cnt_reg <= rst_cnt_next;
      chp_cnt_reg <= chp_cnt_next;
      chp_k_reg <= chp_k_next;
    end
  end

  // Upstream speed handshake
  uhet_up_state_type up_reg;
  uhet_up_state_type up_next;
  logic [31:0] up_cnt_reg;
  logic [31:0] up_cnt_next;
  logic se0_prev_reg;
  logic se0_prev_next;

  always_comb begin
    up_next = up_reg;
    up_cnt_next = up_cnt_reg + 32'h0000_0001;
    se0_prev_next = se0_hit;
    case (up_reg)
      UP_FS: begin
        up_cnt_next = CNT_ZERO;
        // Edge, so a lingering SE0 does not restart the handshake
        if (se0_hit && !se0_prev_reg) begin
          up_next = UP_CHIRP;
        end
      end
      UP_HS: begin
        up_cnt_next = CNT_ZERO;
        if (pins_s.up_se0) begin
          up_next = UP_REV;
        end
      end
      UP_REV: begin
        if (!pins_s.up_se0) begin
          up_next = UP_HS;
          up_cnt_next = CNT_ZERO;
        end else if (up_cnt_reg == REV_CYC - 1) begin
          up_next = UP_CHIRP;
          up_cnt_next = CNT_ZERO;
        end
      end
      UP_CHIRP: begin
        if (up_cnt_reg == UCH_CYC - 1) begin
          up_next = UP_WAIT;
          up_cnt_next = CNT_ZERO;
        end
      end
      UP_WAIT: begin
        if (host_hit) begin
          up_next = UP_HS;
          up_cnt_next = CNT_ZERO;
        end else if (up_cnt_reg == WTFS_CYC - 1) begin
          up_next = UP_FS;
          up_cnt_next = CNT_ZERO;
        end
      end
      default: begin
        up_next = UP_FS;
        up_cnt_next = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      up_reg <= UP_FS;
      up_cnt_reg <= CNT_ZERO;
      se0_prev_reg <= 1'b0;
    end else begin
      up_reg <= up_next;
      up_cnt_reg <= up_cnt_next;
      se0_prev_reg <= se0_prev_next;
    end
  end

  // Resume drive, packet gaps, babble and SuperSpeed events
  logic [31:0] rsm_dn_cnt_reg;
  logic [31:0] rsm_dn_cnt_next;
  logic [31:0] rsm_up_cnt_reg;
  logic [31:0] rsm_up_cnt_next;
  logic [7:0] tx_gap_reg;
  logic [7:0] tx_gap_next;
  logic [7:0] rx_gap_reg;
  logic [7:0] rx_gap_next;
  logic [10:0] sym_cnt_reg;
  logic [10:0] sym_cnt_next;
  logic in_pkt_reg;
  logic in_pkt_next;
  logic babble_next;
  uhet_out_type out_next;

  always_comb begin
    rsm_dn_cnt_next = (rsm_dn_cnt_reg == CNT_ZERO) ? CNT_ZERO : rsm_dn_cnt_reg - 32'h0000_0001;
    rsm_up_cnt_next = (rsm_up_cnt_reg == CNT_ZERO) ? CNT_ZERO : rsm_up_cnt_reg - 32'h0000_0001;
    if (req.resume_dn) begin
      rsm_dn_cnt_next = RSM_DN_CYC;
    end
    if (req.resume_up) begin
      rsm_up_cnt_next = RSM_UP_CYC;
    end
    // Counters saturate at their gap so they never wrap
    tx_gap_next = (tx_gap_reg < GAP_SAME_C) ? tx_gap_reg + 8'h01 : tx_gap_reg;
    rx_gap_next = (rx_gap_reg < GAP_OPP_C) ? rx_gap_reg + 8'h01 : rx_gap_reg;
    if (req.hs_tx_end) begin
      tx_gap_next = 8'h00;
    end
    if (req.hs_rx_end) begin
      rx_gap_next = 8'h00;
    end
    in_pkt_next = in_pkt_reg;
    sym_cnt_next = sym_cnt_reg;
    babble_next = 1'b0;
    if (req.dpp_start) begin
      in_pkt_next = 1'b1;
      sym_cnt_next = SYM_RESET;
    end else if (req.dpp_end) begin
      in_pkt_next = 1'b0;
    end else if (in_pkt_reg && req.dpp_sym) begin
      sym_cnt_next = sym_cnt_reg + 11'h001;
      if (sym_cnt_next == BABBLE_SYMS) begin
        babble_next = 1'b1;
        in_pkt_next = 1'b0;
      end
    end
    out_next.connect = attach_hit;
    out_next.disconnect = detach_hit;
    out_next.resume_dn_drv = rsm_dn_cnt_next != CNT_ZERO;
    out_next.resume_bcast = pins_s.dn_resume;
    out_next.reset_drv = dr_next != DR_IDLE;
    out_next.chirp_k_dn = (dr_next == DR_CHIRP) && chp_k_next;
    out_next.chirp_j_dn = (dr_next == DR_CHIRP) && !chp_k_next;
    out_next.long_k = longk_hit;
    out_next.long_se0 = se0_hit;
    out_next.up_chirp_k = up_next == UP_CHIRP;
    out_next.hs_mode = (up_next == UP_HS) || (up_next == UP_REV);
    out_next.resume_up_drv = rsm_up_cnt_next != CNT_ZERO;
    out_next.gap_ok = (tx_gap_next >= GAP_SAME_C) && (rx_gap_next >= GAP_OPP_C);
    out_next.u0_exit = req.ss_route_lp;
    out_next.babble = babble_next;
    out_next.wake_up = req.ss_remote_wake && req.up_u3;
    out_next.warm_fail = warm_hit;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsm_dn_cnt_reg <= CNT_ZERO;
      rsm_up_cnt_reg <= CNT_ZERO;
      tx_gap_reg <= GAP_SAME_C;
      rx_gap_reg <= GAP_OPP_C;
      sym_cnt_reg <= SYM_RESET;
      in_pkt_reg <= 1'b0;
      evt <= '0;
    end else begin
      rsm_dn_cnt_reg <= rsm_dn_cnt_next;
      rsm_up_cnt_reg <= rsm_up_cnt_next;
      tx_gap_reg <= tx_gap_next;
      rx_gap_reg <= rx_gap_next;
      sym_cnt_reg <= sym_cnt_next;
      in_pkt_reg <= in_pkt_next;
      evt <= out_next;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_reset_ends_on_count: assert property (
    dr_reg != DR_IDLE && rst_cnt_reg == CNT_ZERO |=> !evt.reset_drv && dr_reg == DR_IDLE)
    else $error("downstream reset did not end at count zero");
  a_chirp_starts_prompt: assert property (
    dr_reg == DR_DEVK && !devk_hit && rst_cnt_reg >= TAIL_CYC |=> evt.chirp_k_dn)
    else $error("hub chirp K did not follow device chirp end");
  // Entry into the chirp forces K, so only flips made inside the chirp count
  a_chirp_full_period: assert property (
    $past(dr_reg) == DR_CHIRP && $changed(chp_k_reg) |-> $past(chp_cnt_reg) == CHIRP_CYC - 1)
    else $error("chirp polarity flipped before a full period");
  a_chirp_tail_clear: assert property (
    dr_reg == DR_CHIRP |-> rst_cnt_reg >= DCHSE0_CYC)
    else $error("chirp still running inside the reset tail");
  a_revert_full_speed: assert property (
    up_reg == UP_REV && pins_s.up_se0 && up_cnt_reg == REV_CYC - 1
      |=> up_reg == UP_CHIRP && !evt.hs_mode)
    else $error("high-speed revert not taken on time");
  a_up_chirp_length: assert property (
    $fell(evt.up_chirp_k) |-> $past(up_cnt_reg) == UCH_CYC - 1)
    else $error("upstream chirp K ended early");
  a_hs_entry: assert property (
    up_reg == UP_WAIT && host_hit |=> evt.hs_mode)
    else $error("high-speed state not entered after host chirp");
  a_fs_fallback: assert property (
    up_reg == UP_WAIT && !host_hit && up_cnt_reg == WTFS_CYC - 1 |=> up_reg == UP_FS)
    else $error("full-speed fallback missed");
  a_gap_same_dir: assert property (
    req.hs_tx_end |=> !evt.gap_ok [*8])
    else $error("transmit allowed too soon after own packet");
  a_babble_count: assert property (
    evt.babble |-> $past(sym_cnt_reg) == BABBLE_SYMS - 11'h001)
    else $error("babble flagged at wrong symbol count");
  a_u0_exit_prompt: assert property (
    req.ss_route_lp |=> evt.u0_exit)
    else $error("U0 exit not started next cycle");
  a_wake_forward: assert property (
    req.ss_remote_wake && req.up_u3 |=> evt.wake_up)
    else $error("remote wake not forwarded");
  a_resume_dn_hold: assert property (
    $rose(evt.resume_dn_drv) |=> evt.resume_dn_drv [*8])
    else $error("downstream resume dropped early");
  a_resume_up_hold: assert property (
    $rose(evt.resume_up_drv) |=> evt.resume_up_drv [*8])
    else $error("upstream resume dropped early");
  a_bcast_follow: assert property (
    pins_s.dn_resume |=> evt.resume_bcast)
    else $error("resume not rebroadcast");
  a_warm_cause: assert property (
    $rose(evt.warm_fail) |-> $past(req.warm_reset, 2))
    else $error("warm reset failure without warm reset");

  c_dn_chirp: cover property ($rose(evt.chirp_j_dn));
  c_hs_entered: cover property (up_reg == UP_WAIT ##1 up_reg == UP_HS);
  c_babble: cover property (evt.babble);
  c_fs_fallback: cover property (up_reg == UP_WAIT ##1 up_reg == UP_FS);

endmodule : uhet_top
`default_nettype wire

// file: uhet_far_model.sv
/*
  Far-side model: upstream host line states and an attached device.
  Assumes the bench sets host_lines; the device answers a port reset.
*/
`timescale 1ns/10ps
`default_nettype none
module uhet_far_model
  import uhet_pkg::*;
#(
  parameter int unsigned DEV_DLY = 20,
  parameter int unsigned DEV_K = 700
) (
  input wire logic ref_clk,
  input wire uhet_pins_type host_lines,
  input wire logic reset_drv,
  output var uhet_pins_type pins
);
  logic dev_k_reg;

  initial dev_k_reg = 1'b0;

  // Device chirp K held past the hub filter, else the hub never answers
  always @(posedge reset_drv) begin
    repeat (DEV_DLY) @(posedge ref_clk);
    dev_k_reg <= 1'b1;
    repeat (DEV_K) @(posedge ref_clk);
    dev_k_reg <= 1'b0;
  end

  always_comb begin
    pins = host_lines;
    pins.dn_chirp_k = host_lines.dn_chirp_k | dev_k_reg;
  end
endmodule : uhet_far_model
`default_nettype wire

// file: uhet_top_bench.sv
/*
  Self-checking bench for the hub event timer with the far-side model.
  Assumes shortened counts; drives on rising edges, samples 1 ns later.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module uhet_top_bench
  import uhet_pkg::*;
;
  localparam int RSM_DN = 200, RSM_UP = 100, RST = 2000, CHIRP = 50;
  localparam int TAIL = 300, REV = 100, UCH = 100, WTFS = 1000, WARM = 200;
  logic ref_clk, arst_n;
  uhet_pins_type pin_cmd, pins;
  uhet_req_type rq;
  uhet_out_type evt;
  logic [16:0] ev;
  int bad_count, check_count, babble_seen;
  // Gap bit inverted so every event reads 1 when active
  assign ev = evt ^ 17'h00010;

  uhet_top #(.RSM_DN_CYC(RSM_DN), .RST_DN_CYC(RST), .CHIRP_CYC(CHIRP),
    .DCHSE0_CYC(TAIL), .RSM_UP_CYC(RSM_UP), .REV_CYC(REV), .UCH_CYC(UCH),
    .WTFS_CYC(WTFS), .WARM_CYC(WARM)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
    .pins(pins), .req(rq), .evt(evt));
  uhet_far_model far_u (.ref_clk(ref_clk), .host_lines(pin_cmd),
    .reset_drv(evt.reset_drv), .pins(pins));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Mid-cycle, so the one-clock pulse is read after it has settled
  always @(negedge ref_clk) if (evt.babble === 1'b1) babble_seen++;

  task automatic rise(input int b, lim, output int n);
    n = 0;
    while (n < lim && ev[b] !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : rise
  task automatic hold(input int b, lim, output int n);
    n = 0;
    while (n < lim && ev[b] === 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : hold
  task automatic set_pin(input int b, logic v);
    @(posedge ref_clk);
    pin_cmd[b] <= v;
    #1;
  endtask : set_pin
  task automatic set_req(input int b, logic v);
    @(posedge ref_clk);
    rq[b] <= v;
    #1;
  endtask : set_req

  task automatic t_filt(input int pb, eb, lim);
    int n;
    set_pin(pb, 1'b1);
    repeat (lim - 50) @(posedge ref_clk);
    set_pin(pb, 1'b0);
    rise(eb, lim, n);
    `CHK(n, lim)
    set_pin(pb, 1'b1);
    rise(eb, lim + 9, n);
    `CHK(n >= lim + 2 && n <= lim + 4, 1'b1)
    set_pin(pb, 1'b0);
    hold(eb, 9, n);
    `CHK(n <= 4, 1'b1)
  endtask : t_filt

  task automatic t_pulse(input int rb, eb, len);
    int n;
    set_req(rb, 1'b1);
    set_req(rb, 1'b0);
    rise(eb, 8, n);
    `CHK(len == 0 ? n == 8 : n <= 1, 1'b1)
    hold(eb, 3000, n);
    `CHK(n, len)
  endtask : t_pulse

  task automatic t_babble;
    for (int i = 1029; i <= 1030; i++) begin
      babble_seen = 0;
      set_req(4, 1'b1);
      set_req(4, 1'b0);
      set_req(3, 1'b1);
      repeat (i - 1) @(posedge ref_clk);
      set_req(3, 1'b0);
      set_req(2, 1'b1);
      set_req(2, 1'b0);
      repeat (3) @(posedge ref_clk);
      `CHK(babble_seen, i - 1029)
    end
  endtask : t_babble

  task automatic t_reset;
    int n, k, last;
    set_req(11, 1'b1);
    set_req(11, 1'b0);
    rise(11, 2000, k);
    `CHK(k >= 718 && k <= 740, 1'b1)
    hold(11, 99, n);
    `CHK(n, CHIRP)
    `CHK(ev[10], 1'b1)
    hold(10, 99, n);
    `CHK(n, CHIRP)
    k = k + 2 * CHIRP;
    last = k;
    while (ev[12] === 1'b1 && k < RST + 9) begin
      @(posedge ref_clk);
      #1;
      k++;
      if (ev[11] === 1'b1 || ev[10] === 1'b1) last = k;
    end
    `CHK(k >= RST && k <= RST + 1, 1'b1)
    `CHK(k - last >= TAIL && k - last <= TAIL + CHIRP + 2, 1'b1)
  endtask : t_reset

  task automatic t_hs;
    int n;
    repeat (1200) @(posedge ref_clk);
    set_pin(2, 1'b1);
    rise(7, 700, n);
    `CHK(n >= 627 && n <= 640, 1'b1)
    hold(7, 200, n);
    `CHK(n, UCH)
    set_pin(2, 1'b0);
    set_pin(0, 1'b1);
    rise(6, 900, n);
    `CHK(n <= 640, 1'b1)
    set_pin(0, 1'b0);
    set_pin(2, 1'b1);
    hold(6, 200, n);
    `CHK(n >= REV && n <= REV + 4, 1'b1)
    set_pin(2, 1'b0);
    rise(6, UCH + WTFS + 50, n);
    `CHK(n, UCH + WTFS + 50)
  endtask : t_hs

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  initial begin
    int n;
    arst_n = 1'b0;
    pin_cmd = '0;
    rq = '0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK(ev, 17'h00000)
    t_filt(7, 16, CYC_FILT);
    t_filt(6, 15, CYC_DISC);
    t_filt(1, 9, CYC_FILT);
    t_filt(2, 8, CYC_FILT);
    set_req(8, 1'b1);
    t_filt(3, 0, WARM);
    set_req(8, 1'b0);
    set_req(7, 1'b1);
    t_pulse(10, 14, RSM_DN);
    t_pulse(9, 5, RSM_UP);
    t_pulse(6, 3, 1);
    t_pulse(5, 1, 1);
    set_req(7, 1'b0);
    t_pulse(5, 1, 0);
    t_pulse(1, 4, CYC_GAP_SAME);
    t_pulse(0, 4, CYC_GAP_OPP);
    t_babble();
    t_reset();
    set_pin(5, 1'b1);
    rise(13, 9, n);
    `CHK(n >= 2 && n <= 4, 1'b1)
    set_pin(5, 1'b0);
    t_hs();
    print_verdict();
  end

  // Whole run is near 16k cycles; this allows six times that
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
endmodule : uhet_top_bench
`undef CHK
`default_nettype wire
